// [functional_error_capture.sv]
// Functional error capture: error flops, global flag, index counter,
// stop-on-error freeze and AHB-Lite register slave.
// Assumes all inputs synchronous to REF_CLK (200 MHz) and one AHB master.
//
// How it works
// R1: Any expected versus actual level difference is a functional error.
// R2: Global error flag is one on a mismatch on any of 64 comparators.
// R3: Flag holds until stop, init, disarm, transfer, log, readback or serial read.
// R4: Mismatches count only while the high or low level gate is active.
// R5: Index counter steps once per pattern row shifted out.
// R6: Index counter reaches at least 262656 rows.
// R7: Renumber with signed offset makes present row one-minus-offset the new row 1.
// R8: Renumbered rows reach the device under test on the next cycle.
// R9: Arm-on-fault clears all error flops and enables monitoring.
// R10: While armed an error halts the test and requests the error handler; the code halts only with pattern RAM off.
// R11: Controller arms before starting the transfer it supervises.
// R12: Armed, pattern RAM off: driver data freezes 100 ns after first error.
// R13: Armed, pattern RAM off: shift clocking stops 100 ns after, index held.
// R14: Disarm-and-clear disables stop-on-error and clears all error flops.
// R15: Arm-on-pass clears error flops and tests for no error.
// R16: Fault read returns one if any selected error flop is set.
// R17: Pass read returns one if any selected error flop is clear.
// R18: Stop-on-error is off after reset and enabled only by arm-on-fault.
// R19: All clock phases stop within 110 ns of the first error.
// R20: Each pin has its own error flop; global flag is their OR.
`timescale 1ns/1ps
`default_nettype none
module functional_error_capture (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic [63:0] EXPECTED,
   input wire logic [63:0] ACTUAL,
   input wire logic HIGH_LEVEL_GATE,
   input wire logic LOW_LEVEL_GATE,
   input wire logic CYCLE_TICK,
   output logic ROW_ADVANCE,
   output logic DRIVE_HOLD,
   output logic PHASE_STOP,
   output logic ERROR_FLAG,
   output logic HANDLER_REQ,
   output logic PASS_RESULT
);

   ////////////////////////////////////////////////////////////////////
   // Functions

   // One if any bit of v is set where mask is set
   function automatic logic any_sel(input logic [63:0] v, input logic [63:0] mask);
      any_sel = |(v & mask);
   endfunction : any_sel

   // Offset equality on the low address byte
   function automatic logic at(input logic [7:0] a, input logic [7:0] ofs);
      at = (a == ofs);
   endfunction : at

   ////////////////////////////////////////////////////////////////////
   // Declarations
   logic ap_valid_r;
   logic ap_write_r;
   logic [7:0] ap_addr_r;
   logic take;
   logic wr_cmd;
   logic wr_cfg;
   logic wr_renum;
   logic wr_sel_lo;
   logic wr_sel_hi;
   ferr_pkg::cmd_s cmd;
   logic clr_flops;
   logic clr_arm;
   logic pram_on_r;
   logic [63:0] sel_r;
   logic armed_r;
   logic pass_mode_r;
   ferr_pkg::freeze_e frz_r;
   ferr_pkg::freeze_e frz_nxt;
   logic [4:0] frz_cnt_r;
   logic [4:0] frz_cnt_nxt;
   logic first_err;
   logic hold_nxt;
   logic handler_nxt;
   logic [63:0] err_vec;
   logic any_err;
   logic hit;
   logic [18:0] idx;
   logic [31:0] status_word;
   logic [31:0] pinrd_word;
   logic [31:0] rd_word;
   logic [7:0] ra;
   ferr_pkg::compare_s cmp_in;
   logic capture_en;
   logic idx_zero;

   ////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase capture
   assign take = HSEL & HTRANS[1] & HREADY;

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_addr_r <= 8'h0;
      end else begin
         ap_valid_r <= take;
         ap_write_r <= take & HWRITE;
         ap_addr_r <= HADDR[7:0];
      end
   end

   // Write strobes in the data phase
   assign wr_cmd = ap_write_r & at(ap_addr_r, ferr_pkg::OFS_CMD);
   assign wr_cfg = ap_write_r & at(ap_addr_r, ferr_pkg::OFS_CFG);
   assign wr_renum = ap_write_r & at(ap_addr_r, ferr_pkg::OFS_RENUM);
   assign wr_sel_lo = ap_write_r & at(ap_addr_r, ferr_pkg::OFS_SEL_LO);
   assign wr_sel_hi = ap_write_r & at(ap_addr_r, ferr_pkg::OFS_SEL_HI);

   // Command pulses
   assign cmd.arm_fault = wr_cmd & HWDATA[ferr_pkg::CMD_ARM_FAULT];
   assign cmd.arm_pass = wr_cmd & HWDATA[ferr_pkg::CMD_ARM_PASS];
   assign cmd.disarm = wr_cmd & HWDATA[ferr_pkg::CMD_DISARM];
   assign cmd.stop = wr_cmd & HWDATA[ferr_pkg::CMD_STOP];
   assign cmd.init = wr_cmd & HWDATA[ferr_pkg::CMD_INIT];
   assign cmd.transfer = wr_cmd & HWDATA[ferr_pkg::CMD_TRANSFER];
   assign cmd.reg_log = wr_cmd & HWDATA[ferr_pkg::CMD_REG_LOG];
   assign cmd.reg_read = wr_cmd & HWDATA[ferr_pkg::CMD_REG_READ];
   assign cmd.ser_read = wr_cmd & HWDATA[ferr_pkg::CMD_SER_READ];

   // Events that clear the error flops and the global flag
   assign clr_flops = |cmd; // [R3] [R9] [R14] [R15]
   // Events that end an armed run
   assign clr_arm = cmd.arm_fault | cmd.arm_pass | cmd.disarm | cmd.stop | cmd.init;

   ////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         pram_on_r <= ferr_pkg::CFG_PRAM_RST;
         sel_r <= ferr_pkg::SEL_RST;
      end else begin
         if (wr_cfg) pram_on_r <= HWDATA[ferr_pkg::CFG_PRAM_ON];
         if (wr_sel_lo) sel_r[31:0] <= HWDATA;
         if (wr_sel_hi) sel_r[63:32] <= HWDATA;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Arm modes: off from reset, each arm command clears the other mode unless both are written at once
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         armed_r <= 1'b0; // [R18]
         pass_mode_r <= 1'b0;
      end else begin
         armed_r <= cmd.arm_fault | (armed_r & ~clr_arm); // [R9] [R14] [R18]
         pass_mode_r <= cmd.arm_pass | (pass_mode_r & ~clr_arm); // [R15]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Comparator bundle and capture enable; capture stops once frozen
   assign cmp_in = '{expected: EXPECTED, actual: ACTUAL, hi_gate: HIGH_LEVEL_GATE, lo_gate: LOW_LEVEL_GATE};
   assign capture_en = (frz_r != ferr_pkg::F_FROZEN);

   // Error flops of the sector cards
   sector_error_bank u_bank (
      .clk(REF_CLK),
      .rst(RST),
      .cmp(cmp_in),
      .capture_en(capture_en),
      .clr(clr_flops),
      .err_r(err_vec),
      .any_r(any_err),
      .hit(hit)
   );

   ////////////////////////////////////////////////////////////////////
   // Stop-on-error freeze timer
   assign first_err = (frz_r == ferr_pkg::F_IDLE) & armed_r & ~pram_on_r & hit;

   always_comb begin
      frz_nxt = frz_r;
      frz_cnt_nxt = frz_cnt_r;
      unique case (frz_r)
         ferr_pkg::F_IDLE: begin
            if (first_err && !clr_arm) begin // [R14]
               frz_nxt = ferr_pkg::F_COUNT;
               frz_cnt_nxt = 5'h1;
            end
         end
         ferr_pkg::F_COUNT: begin
            if (frz_cnt_r == ferr_pkg::FREEZE_LAST) begin
               frz_nxt = ferr_pkg::F_FROZEN; // [R12] [R13] [R19]
            end else begin
               frz_cnt_nxt = 5'(frz_cnt_r + 5'h1);
            end
            if (clr_arm) frz_nxt = ferr_pkg::F_IDLE;
         end
         ferr_pkg::F_FROZEN: begin
            if (clr_arm) frz_nxt = ferr_pkg::F_IDLE;
         end
         default: frz_nxt = ferr_pkg::F_IDLE;
      endcase
   end

   assign hold_nxt = (frz_nxt == ferr_pkg::F_FROZEN);
   // Handler request: set by an armed error, the set wins over a clear
   assign handler_nxt = (armed_r & hit) | (HANDLER_REQ & ~clr_arm); // [R10]

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         frz_r <= ferr_pkg::F_IDLE;
         frz_cnt_r <= 5'h0;
      end else begin
         frz_r <= frz_nxt;
         frz_cnt_r <= frz_cnt_nxt;
      end
   end

   // Registered outputs toward drivers, clock generator and controller
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         DRIVE_HOLD <= 1'b0;
         PHASE_STOP <= 1'b0;
         ROW_ADVANCE <= 1'b0;
         HANDLER_REQ <= 1'b0;
         PASS_RESULT <= 1'b0;
      end else begin
         DRIVE_HOLD <= hold_nxt; // [R12]
         PHASE_STOP <= hold_nxt; // [R19]
         ROW_ADVANCE <= CYCLE_TICK & ~hold_nxt; // [R13]
         HANDLER_REQ <= handler_nxt;
         PASS_RESULT <= pass_mode_r & ~any_err; // [R15]
      end
   end

   assign ERROR_FLAG = any_err; // [R2]

   ////////////////////////////////////////////////////////////////////
   // Row index; renumber applies at once so the next cycle shows it
   assign idx_zero = cmd.stop | cmd.init | cmd.transfer;

   row_index_counter u_index (
      .clk(REF_CLK),
      .rst(RST),
      .adv(ROW_ADVANCE), // [R5]
      .zero(idx_zero),
      .renum(wr_renum), // [R7] [R8]
      .offset(HWDATA[18:0]),
      .idx_r(idx) // [R6]
   );

   ////////////////////////////////////////////////////////////////////
   // Read words
   assign status_word = {26'h0, PASS_RESULT, HANDLER_REQ, pass_mode_r, DRIVE_HOLD, armed_r, any_err};
   assign pinrd_word = {30'h0, any_sel(~err_vec, sel_r), any_sel(err_vec, sel_r)}; // [R16] [R17]
   assign ra = HADDR[7:0];
   assign rd_word = at(ra, ferr_pkg::OFS_CFG) ? {31'h0, pram_on_r}
                  : at(ra, ferr_pkg::OFS_STAT) ? status_word
                  : at(ra, ferr_pkg::OFS_INDEX) ? {13'h0, idx}
                  : at(ra, ferr_pkg::OFS_SEL_LO) ? sel_r[31:0]
                  : at(ra, ferr_pkg::OFS_SEL_HI) ? sel_r[63:32]
                  : at(ra, ferr_pkg::OFS_PINRD) ? pinrd_word
                  : at(ra, ferr_pkg::OFS_ERR_LO) ? err_vec[31:0]
                  : at(ra, ferr_pkg::OFS_ERR_HI) ? err_vec[63:32]
                  : 32'h0;

   // Read data is latched at the address phase, always zero wait, OKAY
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         HRDATA <= 32'h0;
         HREADYOUT <= 1'b0;
         HRESP <= 1'b0;
      end else begin
         HRDATA <= (take & ~HWRITE) ? rd_word : 32'h0;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   sequence s_first_err;
      first_err && !clr_arm;
   endsequence

   sequence s_last_count;
      frz_r == ferr_pkg::F_COUNT && frz_cnt_r == ferr_pkg::FREEZE_LAST && !clr_arm;
   endsequence

   chk_flag_is_or: assert property (ERROR_FLAG == (|err_vec)) // [R20]
      else $error("Global flag differs from OR of pin flops");

   chk_mismatch_sets: assert property (hit |=> ERROR_FLAG) // [R1] [R2]
      else $error("Gated mismatch did not set the flag");

   chk_gate_window: assert property (!HIGH_LEVEL_GATE && !LOW_LEVEL_GATE |=> (err_vec & ~$past(err_vec)) == 64'h0) // [R4]
      else $error("Error flop set outside the gates");

   chk_flag_holds: assert property (ERROR_FLAG && !clr_flops |=> ERROR_FLAG) // [R3]
      else $error("Flag dropped without a clearing event");

   chk_clear_event: assert property (clr_flops && !hit |=> !ERROR_FLAG && err_vec == 64'h0) // [R3] [R9] [R14]
      else $error("Clearing event left errors set");

   chk_index_step: assert property (ROW_ADVANCE && !wr_renum && !clr_flops |=> idx == 19'($past(idx) + 19'h1)) // [R5]
      else $error("Index did not step on a row advance");

   chk_renum_apply: assert property (wr_renum && !ROW_ADVANCE && !clr_flops |=> idx == 19'($past(idx) + $past(HWDATA[18:0]))) // [R7] [R8]
      else $error("Renumber offset not applied");

   chk_freeze_start: assert property (s_first_err |=> (frz_cnt_r == 5'h1) ##0 (!DRIVE_HOLD) [*8]) // [R12]
      else $error("Freeze timer did not start cleanly");

   chk_freeze_time: assert property (s_last_count |=> DRIVE_HOLD && PHASE_STOP ##1 !ROW_ADVANCE) // [R12] [R13] [R19]
      else $error("Freeze not reached at 100 ns");

   chk_armed_halt: assert property (armed_r && hit && !clr_arm |=> HANDLER_REQ) // [R10]
      else $error("Armed error gave no handler request");

   chk_reset_disarmed: assert property (!armed_r && !cmd.arm_fault |=> !armed_r) // [R18]
      else $error("Stop-on-error enabled without arm");

endmodule : functional_error_capture
`default_nettype wire

// [ferr_pkg.sv]
// Shared constants and types of the functional error capture block.
// Assumes a 200 MHz REF_CLK and a 32-bit AHB-Lite register bus.
package ferr_pkg;

   ////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int unsigned PINS = 64;
   localparam int unsigned IDX_W = 19;
   localparam logic [18:0] IDX_MAX = 19'h40200;

   ////////////////////////////////////////////////////////////////////
   // Timing, in ns and in REF_CLK cycles
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned FREEZE_NS = 100;
   localparam int unsigned PHASE_STOP_NS = 110;
   localparam int unsigned FREEZE_CYC_RAW = FREEZE_NS / CLK_PERIOD_NS;
   localparam int unsigned FREEZE_CYC = (FREEZE_CYC_RAW < 1) ? 1 : FREEZE_CYC_RAW;
   localparam logic [4:0] FREEZE_LAST = 5'(FREEZE_CYC - 1);

   ////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_INDEX = 8'h0c;
   localparam logic [7:0] OFS_RENUM = 8'h10;
   localparam logic [7:0] OFS_SEL_LO = 8'h14;
   localparam logic [7:0] OFS_SEL_HI = 8'h18;
   localparam logic [7:0] OFS_PINRD = 8'h1c;
   localparam logic [7:0] OFS_ERR_LO = 8'h20;
   localparam logic [7:0] OFS_ERR_HI = 8'h24;

   ////////////////////////////////////////////////////////////////////
   // Command register bit positions (write one to act)
   localparam int unsigned CMD_ARM_FAULT = 0;
   localparam int unsigned CMD_ARM_PASS = 1;
   localparam int unsigned CMD_DISARM = 2;
   localparam int unsigned CMD_STOP = 3;
   localparam int unsigned CMD_INIT = 4;
   localparam int unsigned CMD_TRANSFER = 5;
   localparam int unsigned CMD_REG_LOG = 6;
   localparam int unsigned CMD_REG_READ = 7;
   localparam int unsigned CMD_SER_READ = 8;

   // Configuration bit, status bits and pin read bits
   localparam int unsigned CFG_PRAM_ON = 0;
   localparam int unsigned ST_ERROR = 0;
   localparam int unsigned ST_ARMED = 1;
   localparam int unsigned ST_FROZEN = 2;
   localparam int unsigned ST_PASS_MODE = 3;
   localparam int unsigned ST_HANDLER = 4;
   localparam int unsigned ST_PASS_OK = 5;
   localparam int unsigned PR_FAULT = 0;
   localparam int unsigned PR_PASS = 1;

   // Reset values
   localparam logic CFG_PRAM_RST = 1'b0;
   localparam logic [63:0] SEL_RST = 64'h0;

   ////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic arm_fault;
      logic arm_pass;
      logic disarm;
      logic stop;
      logic init;
      logic transfer;
      logic reg_log;
      logic reg_read;
      logic ser_read;
   } cmd_s;

   typedef struct packed {
      logic [63:0] expected;
      logic [63:0] actual;
      logic hi_gate;
      logic lo_gate;
   } compare_s;

   typedef enum logic [1:0] {
      F_IDLE = 2'b00,
      F_COUNT = 2'b01,
      F_FROZEN = 2'b10
   } freeze_e;

endpackage : ferr_pkg

// [sector_error_bank.sv]
// Per-pin error flip-flops of the 64 sector cards and their global OR.
// Assumes comparator inputs synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module sector_error_bank (
   input wire logic clk,
   input wire logic rst,
   input wire ferr_pkg::compare_s cmp,
   input wire logic capture_en,
   input wire logic clr,
   output logic [63:0] err_r,
   output logic any_r,
   output logic hit
);

   logic [63:0] gated;
   logic [63:0] err_nxt;

   // Mismatch counts only inside the gate for its expected level
   assign gated = (cmp.expected ^ cmp.actual)
                & ((cmp.expected & {64{cmp.hi_gate}}) | (~cmp.expected & {64{cmp.lo_gate}})); // [R1] [R4]
   assign hit = capture_en & (|gated);
   // A new mismatch wins over a clear in the same cycle
   assign err_nxt = (err_r & {64{~clr}}) | (gated & {64{capture_en}}); // [R20]

   // Flops and their registered OR
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         err_r <= 64'h0;
         any_r <= 1'b0;
      end else begin
         err_r <= err_nxt;
         any_r <= |err_nxt; // [R2] [R20]
      end
   end

endmodule : sector_error_bank
`default_nettype wire

// [row_index_counter.sv]
// Pattern row index counter with signed renumbering.
// Assumes adv pulses once per row shifted out; offset is two's complement.
`timescale 1ns/1ps
`default_nettype none
module row_index_counter (
   input wire logic clk,
   input wire logic rst,
   input wire logic adv,
   input wire logic zero,
   input wire logic renum,
   input wire logic [18:0] offset,
   output logic [18:0] idx_r
);

   logic [18:0] idx_nxt;

   // Renumber shifts the count by the offset, a row advance adds one
   assign idx_nxt = zero ? 19'h0
                  : 19'(idx_r + (renum ? offset : 19'h0) + {18'h0, adv}); // [R5] [R7]

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         idx_r <= 19'h0;
      end else begin
         idx_r <= idx_nxt;
      end
   end

endmodule : row_index_counter
`default_nettype wire

// [dut_levels_model.sv]
// Far-side model: levels of the device under test as seen by the 64 comparators.
// Assumes the bench steers faulty pins, gate windows and pattern ticks.
`timescale 1ns/1ps
`default_nettype none
module dut_levels_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [63:0] fault_mask,
   input wire logic hi_en,
   input wire logic lo_en,
   input wire logic tick_en,
   output logic [63:0] exp_lvl,
   output logic [63:0] act_lvl,
   output logic hi_gate,
   output logic lo_gate,
   output logic tick
);
   logic [1:0] phase_r;
   // Alternating expected pattern; a faulty pin answers the inverse level
   assign exp_lvl = 64'h5555_5555_5555_5555;
   assign act_lvl = exp_lvl ^ fault_mask;
   assign hi_gate = hi_en;
   assign lo_gate = lo_en;
   // One pattern tick every fourth cycle while a run is on
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_r <= 2'h0;
         tick <= 1'b0;
      end else begin
         phase_r <= phase_r + 2'h1;
         tick <= tick_en && (phase_r == 2'h3);
      end
   end
endmodule : dut_levels_model
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the functional error capture block.
// Assumes an AHB-Lite master of its own and the comparator level model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp;
   logic [63:0] fmask = 64'h0;
   logic ghi = 1'b0, glo = 1'b0, tick_en = 1'b0;
   logic [63:0] exp_lvl, act_lvl;
   logic hi_gate, lo_gate, tick, row_adv, drive_hold, phase_stop, err_flag, handler_req, pass_res;
   logic [31:0] rd, w;
   int n_mismatch = 0;
   int check_count = 0;
   int adv_cnt = 0;
   int n, b, v;
   ////////////////////////////////////////////////////////////////////
   // Clock, instances and shift-clock pulse counter
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (row_adv === 1'b1) adv_cnt <= adv_cnt + 1;
   dut_levels_model u_dut_levels_model (.clk(ref_clk), .rst(rst), .fault_mask(fmask), .hi_en(ghi),
      .lo_en(glo), .tick_en(tick_en), .exp_lvl(exp_lvl), .act_lvl(act_lvl), .hi_gate(hi_gate),
      .lo_gate(lo_gate), .tick(tick));
   functional_error_capture u_functional_error_capture (.REF_CLK(ref_clk), .RST(rst), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .EXPECTED(exp_lvl), .ACTUAL(act_lvl),
      .HIGH_LEVEL_GATE(hi_gate), .LOW_LEVEL_GATE(lo_gate), .CYCLE_TICK(tick), .ROW_ADVANCE(row_adv),
      .DRIVE_HOLD(drive_hold), .PHASE_STOP(phase_stop), .ERROR_FLAG(err_flag),
      .HANDLER_REQ(handler_req), .PASS_RESULT(pass_res));
   ////////////////////////////////////////////////////////////////////
   // Verdict, comparison and bus tasks
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   // Waits for an edge with hready high, bounded
   task automatic ready_edge;
      int i;
      for (i = 0; i < 100; i++) begin
         @(posedge ref_clk);
         if (hreadyout === 1'b1) return;
      end
      n_mismatch++;
      conclude();
   endtask : ready_edge
   task automatic bus(input logic wr_n, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr_n;
      ready_edge();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      ready_edge();
      r = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, rd);
   endtask : wr
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, rd);
      chk(what, e, rd);
      chk("hresp", 32'h0, 32'(hresp));
   endtask : rdc
   // One-cycle mismatch on one pin with chosen gates
   task automatic hit(input int pin, input logic hi, input logic lo);
      @(posedge ref_clk);
      fmask <= 64'h1 << pin;
      ghi <= hi;
      glo <= lo;
      @(posedge ref_clk);
      fmask <= 64'h0;
      ghi <= 1'b0;
      glo <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask : hit
   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      rdc("status", ferr_pkg::OFS_STAT, 32'h0);
      rdc("index", ferr_pkg::OFS_INDEX, 32'h0);
      rdc("cfg", ferr_pkg::OFS_CFG, 32'h0);
      rdc("unmapped", 8'h40, 32'h0);
      hit(0, 1'b0, 1'b1);
      chk("flag outside gate", 32'h0, 32'(err_flag));
      hit(0, 1'b1, 1'b0);
      chk("flag", 32'h1, 32'(err_flag));
      rdc("err lo", ferr_pkg::OFS_ERR_LO, 32'h1);
      chk("unarmed handler", 32'h0, 32'(handler_req));
      wr(ferr_pkg::OFS_SEL_LO, 32'h3);
      rdc("pin read two", ferr_pkg::OFS_PINRD, 32'h3);
      wr(ferr_pkg::OFS_SEL_LO, 32'h1);
      rdc("pin read set", ferr_pkg::OFS_PINRD, 32'h1);
      wr(ferr_pkg::OFS_SEL_LO, 32'h0);
      wr(ferr_pkg::OFS_SEL_HI, 32'h8000_0000);
      rdc("pin read clear", ferr_pkg::OFS_PINRD, 32'h2);
      hit(63, 1'b0, 1'b1);
      rdc("err hi", ferr_pkg::OFS_ERR_HI, 32'h8000_0000);
      rdc("pin read hi", ferr_pkg::OFS_PINRD, 32'h1);
      // Each clearing command from disarm to serial read drops the flag and the pin flops
      for (b = ferr_pkg::CMD_DISARM; b <= ferr_pkg::CMD_SER_READ; b++) begin
         hit(5, 1'b1, 1'b1);
         wr(ferr_pkg::OFS_CMD, 32'h1 << b);
         @(posedge ref_clk);
         chk("flag cleared", 32'h0, 32'(err_flag));
         rdc("err cleared", ferr_pkg::OFS_ERR_LO, 32'h0);
      end
      // Index follows the shift clock, then renumbering
      @(posedge ref_clk);
      tick_en <= 1'b1;
      repeat (40) @(posedge ref_clk);
      tick_en <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk("advances seen", 32'h1, 32'(adv_cnt > 0));
      rdc("index count", ferr_pkg::OFS_INDEX, 32'(adv_cnt));
      v = adv_cnt;
      wr(ferr_pkg::OFS_RENUM, 32'h0007_ffcf);
      rdc("renumber", ferr_pkg::OFS_INDEX, 32'((v - 49) & 32'h7ffff));
      wr(ferr_pkg::OFS_CMD, 32'h1 << ferr_pkg::CMD_STOP);
      wr(ferr_pkg::OFS_RENUM, {13'h0, ferr_pkg::IDX_MAX});
      rdc("index max", ferr_pkg::OFS_INDEX, {13'h0, ferr_pkg::IDX_MAX});
      // Armed, pattern RAM off: stop on error
      hit(2, 1'b1, 1'b1);
      wr(ferr_pkg::OFS_CMD, 32'h1 << ferr_pkg::CMD_ARM_FAULT);
      @(posedge ref_clk);
      chk("arm clears", 32'h0, 32'(err_flag));
      rdc("armed", ferr_pkg::OFS_STAT, 32'h1 << ferr_pkg::ST_ARMED);
      tick_en <= 1'b1;
      repeat (10) @(posedge ref_clk);
      fmask <= 64'h4;
      ghi <= 1'b1;
      glo <= 1'b1;
      for (n = 0; n < 40 && drive_hold !== 1'b1; n++) begin
         @(posedge ref_clk);
         if (n == 1) begin
            fmask <= 64'h0;
            ghi <= 1'b0;
            glo <= 1'b0;
         end
      end
      chk("freeze delay", ferr_pkg::FREEZE_CYC + 1, n);
      chk("phase stop", 32'h1, 32'(phase_stop));
      chk("handler", 32'h1, 32'(handler_req));
      w = (32'h1 << ferr_pkg::ST_ERROR) | (32'h1 << ferr_pkg::ST_ARMED);
      w = w | (32'h1 << ferr_pkg::ST_FROZEN) | (32'h1 << ferr_pkg::ST_HANDLER);
      rdc("frozen status", ferr_pkg::OFS_STAT, w);
      v = adv_cnt;
      bus(1'b0, ferr_pkg::OFS_INDEX, 32'h0, w);
      repeat (20) @(posedge ref_clk);
      chk("shift held", 32'(v), 32'(adv_cnt));
      rdc("index held", ferr_pkg::OFS_INDEX, w);
      wr(ferr_pkg::OFS_CMD, 32'h1 << ferr_pkg::CMD_DISARM);
      tick_en <= 1'b0;
      @(posedge ref_clk);
      chk("hold released", 32'h0, 32'(drive_hold));
      rdc("disarmed", ferr_pkg::OFS_STAT, 32'h0);
      // Armed, pattern RAM on: handler without freeze
      wr(ferr_pkg::OFS_CFG, 32'h1);
      wr(ferr_pkg::OFS_CMD, 32'h1 << ferr_pkg::CMD_ARM_FAULT);
      hit(3, 1'b1, 1'b1);
      repeat (30) @(posedge ref_clk);
      chk("no freeze", 32'h0, 32'(drive_hold));
      chk("handler pram", 32'h1, 32'(handler_req));
      wr(ferr_pkg::OFS_CMD, 32'h1 << ferr_pkg::CMD_DISARM);
      wr(ferr_pkg::OFS_CFG, 32'h0);
      // Armed for pass
      wr(ferr_pkg::OFS_CMD, 32'h1 << ferr_pkg::CMD_ARM_PASS);
      repeat (3) @(posedge ref_clk);
      chk("pass clean", 32'h1, 32'(pass_res));
      w = (32'h1 << ferr_pkg::ST_PASS_MODE) | (32'h1 << ferr_pkg::ST_PASS_OK);
      rdc("pass status", ferr_pkg::OFS_STAT, w);
      hit(4, 1'b1, 1'b1);
      chk("pass failed", 32'h0, 32'(pass_res));
      wr(ferr_pkg::OFS_CMD, 32'h1 << ferr_pkg::CMD_DISARM);
      conclude();
   end
endmodule : testbench
`default_nettype wire
